// ===== hw/system_time_counter.sv
// Free-running 40-bit system time counter behind an AHB-Lite register slave.
`timescale 1ns/10ps
// What this block does
// - Provides a 40-bit read-only time value; register writes never change it.
// - One count equals one period of 128 times 500 MHz.
// - With the PLL enabled the count gains 512 per 125 MHz cycle.
// - The nine lowest bits of the count always read as zero.
// - Before PLL enable the count gains 512 at half the crystal frequency.
// - In sleep the count stops and its readable value is frozen.
module system_time_counter
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [39:0] time_value
);

  // ==========================================================
  // Register state
  logic [30:0] units_reg;
  logic [30:0] units_next;
  logic [17:0] acc_reg;
  logic [17:0] acc_next;
  logic [1:0]  ctrl_reg;
  logic [7:0]  hi_snap_reg;
  logic [7:0]  hi_snap_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic        hreadyout_reg;
  logic        hresp_reg;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;

  // ==========================================================
  // Bus decode
  wire         take      = hsel & htrans[1] & hready;
  wire         take_rd   = take & ~hwrite;
  wire         take_wr   = take & hwrite;
  wire [11:0]  a_addr    = haddr[11:0];
  wire         hit_lo    = (a_addr == system_time_value_pkg::TIME_LO_ADDR);
  wire         hit_hi    = (a_addr == system_time_value_pkg::TIME_HI_ADDR);
  wire         hit_ctrl  = (a_addr == system_time_value_pkg::CTRL_ADDR);
  wire         hit_stat  = (a_addr == system_time_value_pkg::STATUS_ADDR);
  // Transfer size is not decoded; every access is taken as a whole word.
  wire         pll_on    = ctrl_reg[system_time_value_pkg::CTRL_PLL_BIT];
  wire         sleeping  = ctrl_reg[system_time_value_pkg::CTRL_SLEEP_BIT];
  // Only the control register accepts writes; time words ignore them.
  // Control writes taken
  wire         ctrl_wr   = wr_pend_reg & (wr_addr_reg == system_time_value_pkg::CTRL_ADDR);

  // ==========================================================
  // Step-rate generator
  // A 40 MHz clock cannot tick at 125 MHz, so a phase accumulator spreads
  // the steps: several 512-unit steps may land in one cycle, and the average
  // rate is exact with no long-term drift.
  // PLL step rate
  wire [17:0]  pll_rate  = 18'(system_time_value_pkg::PLL_STEP_KHZ);
  wire [17:0]  xtal_rate = 18'(system_time_value_pkg::XTAL_STEP_KHZ);
  wire [17:0]  rate_khz  = pll_on ? pll_rate : xtal_rate;
  wire [18:0]  acc_sum   = {1'b0, acc_reg} + {1'b0, rate_khz};

  // Threshold compares replace a divider: the sum never reaches five
  // periods of the bus clock, so four compares cover every case.
  // A divider by a constant would cost far more area for the same answer.
  wire [18:0]  lim_1     = 19'(system_time_value_pkg::HCLK_KHZ);
  wire [18:0]  lim_2     = 19'(2 * system_time_value_pkg::HCLK_KHZ);
  wire [18:0]  lim_3     = 19'(3 * system_time_value_pkg::HCLK_KHZ);
  wire [18:0]  lim_4     = 19'(4 * system_time_value_pkg::HCLK_KHZ);
  wire         over_1    = (acc_sum >= lim_1);
  wire         over_2    = (acc_sum >= lim_2);
  wire         over_3    = (acc_sum >= lim_3);
  wire         over_4    = (acc_sum >= lim_4);
  wire [2:0]   steps     = 3'(over_1) + 3'(over_2) + 3'(over_3)
                           + 3'(over_4);
  wire [18:0]  acc_taken = over_4 ? lim_4 :
                           over_3 ? lim_3 :
                           over_2 ? lim_2 :
                           over_1 ? lim_1 : 19'h0_0000;
  wire [18:0]  acc_rem   = acc_sum - acc_taken;

  // ==========================================================
  // Counter next value
  // The count is held in 512-units, so the low bits cannot be anything
  // but zero and need no storage.
  // Sleep freezes
  always_comb
  begin
    units_next = units_reg;
    if (!sleeping)
    begin
      // A 31-bit adder wraps on its own, so overflow needs no logic and sends no event.
      units_next = units_reg + 31'(steps);
    end
  end

  // The accumulator freezes with the count, so waking resumes the same phase.
  always_comb
  begin
    acc_next = acc_reg;
    if (!sleeping)
    begin
      acc_next = acc_rem[17:0];
    end
  end

  wire [39:0]  full_time = {units_reg, 9'h000};

  // ==========================================================
  // Read words
  wire [31:0]  lo_word   = full_time[31:0];
  wire [7:0]   hi_byte   = full_time[39:32];
  wire [31:0]  hi_word   = {24'h00_0000, hi_snap_reg};
  wire [31:0]  ctrl_word = {30'h0000_0000, ctrl_reg};
  wire [31:0]  stat_word = {30'h0000_0000, ~sleeping, pll_on};

  // ==========================================================
  // Read data
  // Reading the low word snapshots the top byte so that a low-then-high
  // pair of reads returns one coherent 40-bit value.
  always_comb
  begin
    hi_snap_next = hi_snap_reg;
    hrdata_next  = 32'h0000_0000;
    if (take_rd)
    begin
      if (hit_lo)
      begin
        hrdata_next  = lo_word;
        hi_snap_next = hi_byte;
      end
      else if (hit_hi)
      begin
        hrdata_next = hi_word;
      end
      else if (hit_ctrl)
      begin
        hrdata_next = ctrl_word;
      end
      else if (hit_stat)
      begin
        hrdata_next = stat_word;
      end
      else
      begin
        hrdata_next = 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Counter
  // Only reset clears the count; software has no way to load it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      units_reg <= system_time_value_pkg::UNITS_RESET;
    end
    else
    begin
      units_reg <= units_next;
    end
  end

  // ==========================================================
  // Step accumulator
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_reg <= system_time_value_pkg::ACC_RESET;
    end
    else
    begin
      acc_reg <= acc_next;
    end
  end

  // ==========================================================
  // Control register
  // A new setting rules the count from the edge after its data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= system_time_value_pkg::CTRL_RESET;
    end
    else if (ctrl_wr)
    begin
      ctrl_reg <= hwdata[1:0];
    end
  end

  // ==========================================================
  // Write pending
  // Write data arrives one cycle after its address, so the write flag and address are held for the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= take_wr;
    end
  end

  // ==========================================================
  // Write address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_addr_reg <= 12'h000;
    end
    else
    begin
      wr_addr_reg <= a_addr;
    end
  end

  // ==========================================================
  // Bus outputs
  // The slave never inserts wait states and never reports an error,
  // so unmapped addresses simply read as zero.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      hrdata_reg <= hrdata_next;
    end
  end

  // ==========================================================
  // High byte snapshot
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hi_snap_reg <= 8'h00;
    end
    else
    begin
      hi_snap_reg <= hi_snap_next;
    end
  end

  // ==========================================================
  // Ready output
  // Registered constants keep every bus output on a flip-flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_reg <= 1'b1;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Response output
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp_reg <= system_time_value_pkg::HRESP_OKAY;
    end
    else
    begin
      hresp_reg <= system_time_value_pkg::HRESP_OKAY;
    end
  end

  assign hrdata     = hrdata_reg;
  assign hreadyout  = hreadyout_reg;
  assign hresp      = hresp_reg;
  assign time_value = full_time;

endmodule

// ===== pkg/system_time_value_pkg.sv
// Constants for the free-running system time counter and its register slave.
package system_time_value_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0]  TIME_LO_INDEX  = 8'h06;
  localparam logic [11:0] TIME_LO_ADDR   = {2'h0, TIME_LO_INDEX, 2'h0};
  localparam logic [11:0] TIME_HI_ADDR   = 12'h040;
  localparam logic [11:0] CTRL_ADDR      = 12'h044;
  localparam logic [11:0] STATUS_ADDR    = 12'h048;
  localparam int          ADDR_W         = 12;
  // ==========================================================
  // Control fields
  localparam int          CTRL_PLL_BIT   = 0;
  localparam int          CTRL_SLEEP_BIT = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  // ==========================================================
  // Counter layout
  localparam int          TIME_W         = 40;
  localparam int          UNIT_SHIFT     = 9;
  localparam int          UNITS_W        = TIME_W - UNIT_SHIFT;
  localparam logic [30:0] UNITS_RESET    = 31'h0000_0000;
  // ==========================================================
  // Timing in kHz, and step accumulator sizes
  localparam int          HCLK_KHZ       = 40000;
  localparam int          PLL_STEP_KHZ   = 125000;
  localparam int          XTAL_KHZ       = 38400;
  localparam int          XTAL_STEP_KHZ  = XTAL_KHZ / 2;
  localparam int          ACC_W          = 18;
  localparam int          STEPS_W        = 3;
  localparam logic [17:0] ACC_RESET      = 18'h0_0000;
  // ==========================================================
  // Bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic        HRESP_OKAY     = 1'h0;
endpackage

// ===== verification/system_time_counter_chk.sv
// Port checker for the system time counter.
`timescale 1ns/10ps
module system_time_counter_chk
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [39:0] time_value
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================
  // Control shadow, rebuilt from bus traffic
  logic        wr_ctrl_reg;
  logic [1:0]  ctrl_reg;
  logic [7:0]  snap_reg;
  logic        take;
  logic        rd_low;
  logic        rd_high;
  logic [31:0] time_low;
  assign take     = hsel && htrans[1] && hready;
  assign rd_low   = take && !hwrite && haddr[11:0] == system_time_value_pkg::TIME_LO_ADDR;
  assign rd_high  = take && !hwrite && haddr[11:0] == system_time_value_pkg::TIME_HI_ADDR;
  assign time_low = time_value[31:0];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ctrl_reg <= 1'b0;
      ctrl_reg    <= 2'h0;
      snap_reg    <= 8'h00;
    end
    else
    begin
      wr_ctrl_reg <= take && hwrite && haddr[11:0] == system_time_value_pkg::CTRL_ADDR;
      if (wr_ctrl_reg)
        ctrl_reg <= hwdata[1:0];
      if (rd_low)
        snap_reg <= time_value[39:32];
    end
  end
  // ==========================================
  // Assertions
  low_zero_a: assert property (time_value[8:0] == 9'h000)
    else $error("low time bits not zero");
  step_bound_a: assert property ((time_value - $past(time_value)) <= 40'h800)
    else $error("time step too large");
  pll_fast_a: assert property (ctrl_reg == 2'h1 |=>
    (time_value - $past(time_value)) >= 40'h600) else $error("pll rate too slow");
  xtal_slow_a: assert property (ctrl_reg == 2'h0 |=>
    (time_value - $past(time_value)) <= 40'h200) else $error("crystal rate too fast");
  sleep_hold_a: assert property (ctrl_reg[1] |=> $stable(time_value))
    else $error("time moved in sleep");
  read_low_a: assert property (rd_low |=> hrdata == $past(time_low))
    else $error("low read mismatch");
  read_high_a: assert property (rd_high |=> hrdata == {24'h00_0000, $past(snap_reg)})
    else $error("high read mismatch");
  bus_okay_a: assert property (hreadyout && hresp == system_time_value_pkg::HRESP_OKAY)
    else $error("bus not ready or not okay");
  cover property (ctrl_reg == 2'h1);
  cover property (ctrl_reg[1]);
  cover property (take && !hwrite);
  cover property (rd_low ##1 rd_high);
endmodule

bind system_time_counter system_time_counter_chk chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .time_value(time_value));

// ===== verification/tb.sv
// Self-checking bench for the system time counter.
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [39:0] time_value;
  logic [31:0] r;
  logic [31:0] a;
  int          n_fail;
  int          total_checks;
  int          cyc;
  system_time_counter uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .time_value(time_value));
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // ==========================================
  // Bus access, one single word per call
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= system_time_value_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {20'h00000, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Two reads whose address edges lie k cycles apart, so the step count is exact.
  task automatic rate(input int k, input logic [31:0] e);
    logic [31:0] b;
    xfer(1'b0, system_time_value_pkg::TIME_LO_ADDR, 32'h0, b);
    repeat (k - 2) @(posedge hclk);
    xfer(1'b0, system_time_value_pkg::TIME_LO_ADDR, 32'h0, r);
    `CHK(r - b, e)
    `CHK(r[8:0], 9'h000)
    `CHK(time_value[8:0], 9'h000)
    xfer(1'b0, system_time_value_pkg::TIME_HI_ADDR, 32'h0, b);
    `CHK(b, 32'h0)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // A whole run needs well under a thousand cycles.
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} <= '0;
    hsize <= 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, system_time_value_pkg::TIME_HI_ADDR, 32'h0, r);
    `CHK(r, 32'h0)
    xfer(1'b0, 12'h100, 32'h0, r);
    `CHK(r, 32'h0)
    rate(25, 32'h1800);
    xfer(1'b1, system_time_value_pkg::CTRL_ADDR, 32'h1, r);
    rate(8, 32'h3200);
    xfer(1'b1, system_time_value_pkg::CTRL_ADDR, 32'h3, r);
    @(posedge hclk);
    xfer(1'b0, system_time_value_pkg::TIME_LO_ADDR, 32'h0, a);
    xfer(1'b1, system_time_value_pkg::TIME_LO_ADDR, 32'hFFFF_FE00, r);
    xfer(1'b0, system_time_value_pkg::STATUS_ADDR, 32'h0, r);
    `CHK(r, 32'h1)
    repeat (20) @(posedge hclk);
    xfer(1'b0, system_time_value_pkg::TIME_LO_ADDR, 32'h0, r);
    `CHK(r, a)
    xfer(1'b1, system_time_value_pkg::CTRL_ADDR, 32'h0, r);
    rate(25, 32'h1800);
    wrap_up();
  end
endmodule
